// [verilog/adcs_sequencer.sv]
`timescale 1ns/1ns
`include "adcs_regs.svh"

module adcs_sequencer
   import adcs_pkg::*;
#(
   parameter int CONV_TICKS = `ADCS_CONV_TICKS
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [`ADCS_NUM_CH-1:0][9:0] analog_in,
   input wire logic timer_trig,
   output logic conv_end_request
);

   localparam int NCH = `ADCS_NUM_CH;

   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------
   function automatic logic res_hit(input logic [7:0] a);
      res_hit = (a >= `ADCS_OFF_RES) && (a < `ADCS_OFF_RES + 8'(4 * NCH)) && (a[1:0] == 2'h0);
   endfunction : res_hit

   function automatic logic [3:0] res_idx(input logic [7:0] a);
      logic [7:0] d;
      d = a - `ADCS_OFF_RES;
      res_idx = d[5:2];
   endfunction : res_idx

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == `ADCS_OFF_CSR) || (a == `ADCS_OFF_CR) || (a == `ADCS_OFF_CR2) ||
                (a == `ADCS_OFF_STOP) || (a == `ADCS_OFF_PROT) || res_hit(a);
   endfunction : addr_ok

   function automatic logic [3:0] last_chan(input adcs_ctrl_t c);
      last_chan = c.ext ? `ADCS_EXT_CH : {1'b0, c.ch};
   endfunction : last_chan

   function automatic logic [3:0] first_chan(input adcs_ctrl_t c);
      first_chan = (c.mode == `ADCS_MODE_SINGLE) ? last_chan(c) : 4'h0;
   endfunction : first_chan

   function automatic logic [3:0] next_chan(input adcs_ctrl_t c, input logic [3:0] n);
      next_chan = (n == {1'b0, c.ch} && c.ext) ? `ADCS_EXT_CH : n + 4'h1;
   endfunction : next_chan

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [NCH-1:0][9:0] an_s1_r, an_s2_r;
   logic trg_s1_r, trg_s2_r, trg_d_r;
   logic trg_rise;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         an_s1_r <= '0;
         an_s2_r <= '0;
         trg_s1_r <= 1'b0;
         trg_s2_r <= 1'b0;
         trg_d_r <= 1'b0;
      end
      else
      begin
         an_s1_r <= analog_in;
         an_s2_r <= an_s1_r;
         trg_s1_r <= timer_trig;
         trg_s2_r <= trg_s1_r;
         trg_d_r <= trg_s2_r;
      end
   end

   assign trg_rise = trg_s2_r & ~trg_d_r;

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   adcs_ctrl_t ctrl_r, ctrl_nxt;
   logic start_r, start_nxt;
   logic flag_r, flag_nxt;
   logic stop_r, stop_nxt;
   logic prot_r, prot_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic wr_en;
   logic seq_end;
   adcs_state_t state_r, state_nxt;

   assign wr_en = psel & penable & pwrite;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok(paddr);

   always_comb
   begin
      ctrl_nxt = ctrl_r;
      start_nxt = start_r;
      flag_nxt = flag_r;
      stop_nxt = stop_r;
      prot_nxt = prot_r;
      if (wr_en && paddr == `ADCS_OFF_PROT && pwdata[15:8] == `ADCS_PROT_KEY)
         prot_nxt = pwdata[`ADCS_PROT_BIT];
      if (wr_en && paddr == `ADCS_OFF_STOP && prot_r)
         stop_nxt = pwdata[`ADCS_STOP_BIT];
      if (wr_en && !stop_r)
      begin
         if (paddr == `ADCS_OFF_CSR)
         begin
            ctrl_nxt.ch = pwdata[`ADCS_CSR_CH_LSB +: 3];
            ctrl_nxt.ext = pwdata[`ADCS_CSR_EXT];
            ctrl_nxt.ie = pwdata[`ADCS_CSR_IE];
            start_nxt = pwdata[`ADCS_CSR_ST];
            if (!pwdata[`ADCS_CSR_FLAG])
               flag_nxt = 1'b0;
         end
         if (paddr == `ADCS_OFF_CR)
         begin
            ctrl_nxt.mode = pwdata[`ADCS_CR_MODE_LSB +: 2];
            ctrl_nxt.conv_clock_select = pwdata[`ADCS_CR_CKS_LSB +: 2];
            ctrl_nxt.trigger_source_select = pwdata[`ADCS_CR_TRG_LSB +: 3];
         end
         if (paddr == `ADCS_OFF_CR2)
            ctrl_nxt.align = pwdata[`ADCS_CR2_ALIGN];
      end
      if (seq_end)
      begin
         flag_nxt = 1'b1;
         if (ctrl_r.mode != `ADCS_MODE_CSCAN)
            start_nxt = 1'b0;
      end
      if (stop_r)
         start_nxt = 1'b0;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_r <= '0;
         start_r <= 1'b0;
         flag_r <= 1'b0;
         stop_r <= `ADCS_STOP_RST;
         prot_r <= 1'b0;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         start_r <= start_nxt;
         flag_r <= flag_nxt;
         stop_r <= stop_nxt;
         prot_r <= prot_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Scan sequencer
   // ---------------------------------------------------------------
   logic [3:0] cur_r, cur_nxt;
   logic req_r, req_nxt;
   logic kick;
   logic res_we;
   logic conv_done;
   logic [9:0] conv_res;
   adcs_conv_req_t conv_req;

   always_comb
   begin
      state_nxt = state_r;
      cur_nxt = cur_r;
      kick = 1'b0;
      seq_end = 1'b0;
      req_nxt = 1'b0;
      res_we = 1'b0;
      unique case (state_r)
         ADCS_IDLE:
         begin
            if (start_r)
            begin
               cur_nxt = first_chan(ctrl_r);
               if (ctrl_r.trigger_source_select == `ADCS_TRG_SOFT)
               begin
                  kick = 1'b1;
                  state_nxt = ADCS_CONV;
               end
               else
                  state_nxt = ADCS_ARMED;
            end
         end
         ADCS_ARMED:
         begin
            if (!start_r)
               state_nxt = ADCS_IDLE;
            else if (trg_rise && ctrl_r.trigger_source_select == `ADCS_TRG_TIMER)
            begin
               kick = 1'b1;
               state_nxt = ADCS_CONV;
            end
         end
         ADCS_CONV:
         begin
            if (!start_r)
               state_nxt = ADCS_IDLE;
            else if (conv_done)
            begin
               res_we = 1'b1;
               if (cur_r != last_chan(ctrl_r))
               begin
                  cur_nxt = next_chan(ctrl_r, cur_r);
                  kick = 1'b1;
               end
               else
               begin
                  seq_end = 1'b1;
                  req_nxt = ctrl_r.ie;
                  if (ctrl_r.mode == `ADCS_MODE_CSCAN)
                  begin
                     cur_nxt = 4'h0;
                     kick = 1'b1;
                  end
                  else
                     state_nxt = ADCS_IDLE;
               end
            end
         end
         default:
            state_nxt = ADCS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= ADCS_IDLE;
         cur_r <= 4'h0;
         req_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cur_r <= cur_nxt;
         req_r <= req_nxt;
      end
   end

   // One-cycle pulse toward interrupt vector ADCS_IRQ_VECTOR; nothing to clear here
   assign conv_end_request = req_r;

   assign conv_req = '{start: kick, chan: cur_nxt, conv_clock_select: ctrl_r.conv_clock_select};

   adcs_conv_unit #(
      .CONV_TICKS(CONV_TICKS)
   ) u_conv (
      .ref_clk(ref_clk),
      .rst(rst),
      .req(conv_req),
      .abort(~start_r),
      .sample(an_s2_r),
      .done(conv_done),
      .result(conv_res)
   );

   // ---------------------------------------------------------------
   // Result registers and read data
   // ---------------------------------------------------------------
   logic [15:0] res_r [NCH];
   logic [15:0] res_nxt [NCH];

   always_comb
   begin
      for (int i = 0; i < NCH; i++)
      begin
         res_nxt[i] = res_r[i];
         if (res_we && cur_r == 4'(i))
            res_nxt[i] = ctrl_r.align ? {conv_res, 6'h00} : {6'h00, conv_res};
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < NCH; i++)
            res_r[i] <= 16'h0000;
      end
      else
      begin
         for (int i = 0; i < NCH; i++)
            res_r[i] <= res_nxt[i];
      end
   end

   always_comb
   begin
      prdata_nxt = prdata_r;
      if (psel && !penable && !pwrite)
      begin
         prdata_nxt = 32'h0000_0000;
         if (paddr == `ADCS_OFF_CSR)
            prdata_nxt[7:0] = {start_r, ctrl_r.ie, flag_r, state_r != ADCS_IDLE,
                               ctrl_r.ext, ctrl_r.ch};
         else if (paddr == `ADCS_OFF_CR)
            prdata_nxt[6:0] = {ctrl_r.trigger_source_select, ctrl_r.conv_clock_select, ctrl_r.mode};
         else if (paddr == `ADCS_OFF_CR2)
            prdata_nxt[`ADCS_CR2_ALIGN] = ctrl_r.align;
         else if (paddr == `ADCS_OFF_STOP)
            prdata_nxt[`ADCS_STOP_BIT] = stop_r;
         else if (paddr == `ADCS_OFF_PROT)
            prdata_nxt[`ADCS_PROT_BIT] = prot_r;
         else if (res_hit(paddr))
            prdata_nxt[15:0] = res_r[res_idx(paddr)];
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         prdata_r <= 32'h0000_0000;
      else
         prdata_r <= prdata_nxt;
   end

   assign prdata = prdata_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_stop_write;
      wr_en && paddr == `ADCS_OFF_CSR && !pwdata[`ADCS_CSR_ST] && !stop_r;
   endsequence

   sequence s_back_idle;
      !start_r ##1 state_r == ADCS_IDLE;
   endsequence

   property p_single_once;
      state_r == ADCS_CONV && start_r && conv_done && ctrl_r.mode == `ADCS_MODE_SINGLE
      |=> state_r == ADCS_IDLE && !start_r ##1 state_r == ADCS_IDLE;
   endproperty
   a_single_once: assert property (p_single_once) else $error("single mode did not stop");

   property p_scan_first;
      state_r == ADCS_IDLE && start_r && ctrl_r.mode != `ADCS_MODE_SINGLE |=> cur_r == 4'h0;
   endproperty
   a_scan_first: assert property (p_scan_first) else $error("scan did not begin at 0");

   property p_scan_up;
      state_r == ADCS_CONV && start_r && conv_done && cur_r != last_chan(ctrl_r)
      |=> cur_r == next_chan($past(ctrl_r), $past(cur_r));
   endproperty
   a_scan_up: assert property (p_scan_up) else $error("scan order wrong");

   property p_sscan_req;
      seq_end && ctrl_r.mode == `ADCS_MODE_SSCAN && ctrl_r.ie
      |=> conv_end_request ##1 !conv_end_request;
   endproperty
   a_sscan_req: assert property (p_sscan_req) else $error("no request at scan end");

   property p_cscan_restart;
      seq_end && ctrl_r.mode == `ADCS_MODE_CSCAN && !stop_r && start_nxt
      |=> state_r == ADCS_CONV && cur_r == 4'h0 && start_r;
   endproperty
   a_cscan_restart: assert property (p_cscan_restart) else $error("scan did not restart");

   property p_ie_gate;
      conv_end_request |-> $past(ctrl_r.ie) && $past(seq_end);
   endproperty
   a_ie_gate: assert property (p_ie_gate) else $error("request without enable");

   property p_stop;
      s_stop_write ##0 state_r != ADCS_IDLE |=> s_back_idle;
   endproperty
   a_stop: assert property (p_stop) else $error("start bit 0 did not stop");

   property p_stopped_ignore;
      stop_r && wr_en |=> ctrl_r == $past(ctrl_r);
   endproperty
   a_stopped_ignore: assert property (p_stopped_ignore) else $error("write while stopped");

   property p_result;
      res_we |=> res_r[$past(cur_r)] == ($past(ctrl_r.align) ? {$past(conv_res), 6'h00}
                                          : {6'h00, $past(conv_res)});
   endproperty
   a_result: assert property (p_result) else $error("result not stored");

   property p_auto_clear;
      seq_end && ctrl_r.mode != `ADCS_MODE_CSCAN |=> !start_r;
   endproperty
   a_auto_clear: assert property (p_auto_clear) else $error("start bit not cleared");

endmodule : adcs_sequencer

// [verilog/adcs_regs.svh]
// Behaviour
// - Single channel mode converts the selected input once, then stops.
// - Scan modes convert selected inputs in turn, lowest channel first, upward.
// - Single scan runs one cycle and raises the conversion-end request at its end.
// - Continuous scan restarts the cycle after each end until software stops it.
// - Conversion-end request only issues while the interrupt enable bit is set.
// - Mode field 0 selects single channel, 2 selects continuous scan.
// - Conversion clock select value 2 gives peripheral clock divided by two.
// - Trigger source 0 is software start, 001b arms timer compare-match start.
// - Channel field 000b picks input 0; in scan 010b picks inputs 0 to 2.
// - Alignment bit 1 places each 10-bit result left-justified.
// - Each input has its own result register: 0 to A, 1 to B, 2 to C.
// - Writing 1 to start bit begins or arms conversion; writing 0 stops it.
// - The request flag in the interrupt controller clears itself when accepted.
// - Conversion-end request goes to vector 98, gated by the controller enable.
// - Converter leaves reset module-stopped; software clears stop before any setting.
// - Alignment bit 0 places each result right-justified.
// - Eight regular analog inputs plus one extended input channel.
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ADCS_OFF_CSR 8'h00
`define ADCS_OFF_CR 8'h04
`define ADCS_OFF_CR2 8'h08
`define ADCS_OFF_STOP 8'h0c
`define ADCS_OFF_PROT 8'h10
`define ADCS_OFF_RES 8'h20

// ---------------------------------------------------------------
// Field positions and codes
// ---------------------------------------------------------------
`define ADCS_CSR_CH_LSB 0
`define ADCS_CSR_EXT 3
`define ADCS_CSR_BUSY 4
`define ADCS_CSR_FLAG 5
`define ADCS_CSR_IE 6
`define ADCS_CSR_ST 7
`define ADCS_CR_MODE_LSB 0
`define ADCS_CR_CKS_LSB 2
`define ADCS_CR_TRG_LSB 4
`define ADCS_CR2_ALIGN 0
`define ADCS_STOP_BIT 0
`define ADCS_PROT_BIT 1
`define ADCS_PROT_KEY 8'ha5
`define ADCS_MODE_SINGLE 2'h0
`define ADCS_MODE_SSCAN 2'h1
`define ADCS_MODE_CSCAN 2'h2
`define ADCS_TRG_SOFT 3'h0
`define ADCS_TRG_TIMER 3'h1
`define ADCS_EXT_CH 4'h8
`define ADCS_NUM_CH 9
`define ADCS_IRQ_VECTOR 98

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define ADCS_STOP_RST 1'b1
`define ADCS_CKS_RST 2'h0
`define ADCS_CLK_PERIOD_NS 20
`define ADCS_CONV_TIME_NS 1000
`define ADCS_CONV_TICKS (`ADCS_CONV_TIME_NS / `ADCS_CLK_PERIOD_NS)

`endif

// [verilog/adcs_pkg.sv]
package adcs_pkg;

   typedef enum logic [1:0] {
      ADCS_IDLE = 2'b00,
      ADCS_ARMED = 2'b01,
      ADCS_CONV = 2'b10
   } adcs_state_t;

   typedef struct packed {
      logic [2:0] ch;
      logic ext;
      logic ie;
      logic align;
      logic [1:0] mode;
      logic [1:0] conv_clock_select;
      logic [2:0] trigger_source_select;
   } adcs_ctrl_t;

   typedef struct packed {
      logic start;
      logic [3:0] chan;
      logic [1:0] conv_clock_select;
   } adcs_conv_req_t;

endpackage : adcs_pkg

// [verilog/adcs_conv_unit.sv]
`timescale 1ns/1ns
`include "adcs_regs.svh"

module adcs_conv_unit
   import adcs_pkg::*;
#(
   parameter int CONV_TICKS = `ADCS_CONV_TICKS
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire adcs_conv_req_t req,
   input wire logic abort,
   input wire logic [`ADCS_NUM_CH-1:0][9:0] sample,
   output logic done,
   output logic [9:0] result
);

   logic busy_r, busy_nxt;
   logic [3:0] chan_r, chan_nxt;
   logic [1:0] cks_r, cks_nxt;
   logic [2:0] pre_r, pre_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic done_r, done_nxt;
   logic [9:0] res_r, res_nxt;

   // ---------------------------------------------------------------
   // Prescaler and fixed-latency conversion
   // ---------------------------------------------------------------
   always_comb
   begin
      busy_nxt = busy_r;
      chan_nxt = chan_r;
      cks_nxt = cks_r;
      pre_nxt = pre_r;
      cnt_nxt = cnt_r;
      done_nxt = 1'b0;
      res_nxt = res_r;
      if (req.start)
      begin
         busy_nxt = 1'b1;
         chan_nxt = req.chan;
         cks_nxt = req.conv_clock_select;
         pre_nxt = 3'h0;
         cnt_nxt = 8'h00;
      end
      else if (abort)
         busy_nxt = 1'b0;
      else if (busy_r)
      begin
         if (pre_r == (3'h7 >> cks_r))
         begin
            pre_nxt = 3'h0;
            if (cnt_r == 8'(CONV_TICKS - 1))
            begin
               busy_nxt = 1'b0;
               done_nxt = 1'b1;
               res_nxt = sample[chan_r];
            end
            else
               cnt_nxt = cnt_r + 8'h01;
         end
         else
            pre_nxt = pre_r + 3'h1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         busy_r <= 1'b0;
         chan_r <= 4'h0;
         cks_r <= `ADCS_CKS_RST;
         pre_r <= 3'h0;
         cnt_r <= 8'h00;
         done_r <= 1'b0;
         res_r <= 10'h000;
      end
      else
      begin
         busy_r <= busy_nxt;
         chan_r <= chan_nxt;
         cks_r <= cks_nxt;
         pre_r <= pre_nxt;
         cnt_r <= cnt_nxt;
         done_r <= done_nxt;
         res_r <= res_nxt;
      end
   end

   assign done = done_r;
   assign result = res_r;

endmodule : adcs_conv_unit

// [testbench/adcs_analog_src.sv]
`timescale 1ns/1ns
`include "adcs_regs.svh"

module adcs_analog_src
#(
   parameter int TRIG_DELAY = 5
)
(
   input wire logic ref_clk,
   input wire logic bank,
   input wire logic fire,
   output logic [`ADCS_NUM_CH-1:0][9:0] analog_in,
   output logic timer_trig
);
   int cnt = 0;
   logic fire_d = 1'b0;

   // ---------------------------------------------------------------
   // Analog levels, one distinct value per input
   // ---------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < `ADCS_NUM_CH; i++)
      begin
         analog_in[i] = 10'(10'h155 + 10'h21 * 10'(i)) ^ {bank, 9'h000};
      end
   end

   // ---------------------------------------------------------------
   // Compare-match event, low outside the two-cycle pulse
   // ---------------------------------------------------------------
   initial timer_trig = 1'b0;
   always @(posedge ref_clk)
   begin
      fire_d <= fire;
      if (fire && !fire_d)
         cnt <= TRIG_DELAY;
      else if (cnt > 0)
         cnt <= cnt - 1;
      timer_trig <= (cnt == 2) || (cnt == 1);
   end
endmodule : adcs_analog_src

// [testbench/testbench.sv]
`timescale 1ns/1ns
`include "adcs_regs.svh"

module testbench;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [`ADCS_NUM_CH-1:0][9:0] analog_in;
   logic timer_trig;
   logic conv_end_request;
   logic bank = 1'b0;
   logic fire = 1'b0;
   logic last_err;
   int n_errors = 0;
   int compares = 0;
   int n_req = 0;
   int cyc = 0;

   adcs_sequencer #(.CONV_TICKS(4)) dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .analog_in(analog_in), .timer_trig(timer_trig),
      .conv_end_request(conv_end_request));

   adcs_analog_src src (.ref_clk(ref_clk), .bank(bank), .fire(fire), .analog_in(analog_in),
      .timer_trig(timer_trig));

   // ---------------------------------------------------------------
   // Clock, request counter and hang limit
   // ---------------------------------------------------------------
   initial
   begin
      forever #10 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
   begin
      if (conv_end_request === 1'b1)
         n_req <= n_req + 1;
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors = n_errors + 1;
         final_report();
      end
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic final_report();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares = compares + 1;
      if (got !== exp)
      begin
         n_errors = n_errors + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      apb(1'b1, a, d, rd);
   endtask : wr

   task automatic rdr(input logic [7:0] a, output logic [31:0] rd);
      apb(1'b0, a, 32'h0000_0000, rd);
   endtask : rdr

   task automatic wait_idle();
      logic [31:0] rd;
      int k;
      k = 0;
      do
      begin
         rdr(`ADCS_OFF_CSR, rd);
         k++;
      end
      while (rd[7] !== 1'b0 && k < 500);
      if (rd[7] !== 1'b0)
      begin
         n_errors = n_errors + 1;
         final_report();
      end
   endtask : wait_idle

   function automatic logic [9:0] smp(input int i, input logic b);
      return 10'(10'h155 + 10'h21 * 10'(i)) ^ {b, 9'h000};
   endfunction : smp

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_stop_protect();
      logic [31:0] rd;
      wr(`ADCS_OFF_CSR, 32'h0000_00c1);
      rdr(`ADCS_OFF_CSR, rd);
      chk(rd, 32'h0000_0000);
      rdr(`ADCS_OFF_STOP, rd);
      chk(rd, 32'h0000_0001);
      wr(`ADCS_OFF_STOP, 32'h0000_0000);
      rdr(`ADCS_OFF_STOP, rd);
      chk(rd, 32'h0000_0001);
      rdr(8'h60, rd);
      chk({31'h0, last_err}, 32'h0000_0001);
      wr(`ADCS_OFF_PROT, 32'h0000_a502);
      wr(`ADCS_OFF_STOP, 32'h0000_0000);
      wr(`ADCS_OFF_PROT, 32'h0000_a500);
      rdr(`ADCS_OFF_STOP, rd);
      chk(rd, 32'h0000_0000);
   endtask : t_stop_protect

   task automatic t_single_left();
      logic [31:0] rd;
      int r0;
      int k;
      wr(`ADCS_OFF_CSR, 32'h0000_0000);
      wr(`ADCS_OFF_CR, 32'h0000_0008);
      wr(`ADCS_OFF_CR2, 32'h0000_0001);
      r0 = n_req;
      wr(`ADCS_OFF_CSR, 32'h0000_00c0);
      k = 0;
      do
      begin
         @(posedge ref_clk);
         k++;
      end
      while (conv_end_request !== 1'b1 && k < 100);
      chk(32'(k), 32'h0000_000b);
      wait_idle();
      repeat (3) @(posedge ref_clk);
      chk(32'(n_req - r0), 32'h0000_0001);
      rdr(`ADCS_OFF_RES, rd);
      chk(rd, {16'h0, smp(0, 1'b0), 6'h00});
      rdr(`ADCS_OFF_RES + 8'h04, rd);
      chk(rd, 32'h0000_0000);
      rdr(`ADCS_OFF_CSR, rd);
      chk({24'h0, rd[7:4]}, 32'h0000_0006);
   endtask : t_single_left

   task automatic t_scan_no_irq();
      logic [31:0] rd;
      int r0;
      wr(`ADCS_OFF_CR, 32'h0000_0009);
      wr(`ADCS_OFF_CR2, 32'h0000_0000);
      r0 = n_req;
      wr(`ADCS_OFF_CSR, 32'h0000_008a);
      wait_idle();
      repeat (3) @(posedge ref_clk);
      chk(32'(n_req - r0), 32'h0000_0000);
      for (int i = 0; i < 3; i++)
      begin
         rdr(`ADCS_OFF_RES + 8'(4 * i), rd);
         chk(rd, {22'h0, smp(i, 1'b0)});
      end
      rdr(`ADCS_OFF_RES + 8'h0c, rd);
      chk(rd, 32'h0000_0000);
      rdr(`ADCS_OFF_RES + 8'h20, rd);
      chk(rd, {22'h0, smp(8, 1'b0)});
      r0 = n_req;
      wr(`ADCS_OFF_CSR, 32'h0000_00c2);
      wait_idle();
      repeat (3) @(posedge ref_clk);
      chk(32'(n_req - r0), 32'h0000_0001);
   endtask : t_scan_no_irq

   task automatic t_continuous();
      logic [31:0] rd;
      int r0;
      int k;
      bank <= 1'b1;
      wr(`ADCS_OFF_CR, 32'h0000_000a);
      r0 = n_req;
      wr(`ADCS_OFF_CSR, 32'h0000_00c2);
      k = 0;
      while (n_req - r0 < 2 && k < 2000)
      begin
         @(posedge ref_clk);
         k++;
      end
      chk(32'(n_req - r0), 32'h0000_0002);
      rdr(`ADCS_OFF_CSR, rd);
      chk({31'h0, rd[7]}, 32'h0000_0001);
      rdr(`ADCS_OFF_RES + 8'h08, rd);
      chk(rd, {22'h0, smp(2, 1'b1)});
      wr(`ADCS_OFF_CSR, 32'h0000_0042);
      repeat (3) @(posedge ref_clk);
      r0 = n_req;
      repeat (200) @(posedge ref_clk);
      chk(32'(n_req - r0), 32'h0000_0000);
      rdr(`ADCS_OFF_CSR, rd);
      chk({24'h0, rd[7:4] & 4'h9}, 32'h0000_0000);
   endtask : t_continuous

   task automatic t_timer();
      logic [31:0] rd;
      int r0;
      int k;
      bank <= 1'b0;
      wr(`ADCS_OFF_CR, 32'h0000_0018);
      r0 = n_req;
      wr(`ADCS_OFF_CSR, 32'h0000_00c1);
      repeat (100) @(posedge ref_clk);
      chk(32'(n_req - r0), 32'h0000_0000);
      fire <= 1'b1;
      k = 0;
      while (n_req == r0 && k < 500)
      begin
         @(posedge ref_clk);
         k++;
      end
      fire <= 1'b0;
      chk(32'(n_req - r0), 32'h0000_0001);
      rdr(`ADCS_OFF_RES + 8'h04, rd);
      chk(rd, {22'h0, smp(1, 1'b0)});
   endtask : t_timer

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      t_stop_protect();
      t_single_left();
      t_scan_no_irq();
      t_continuous();
      t_timer();
      final_report();
   end
endmodule : testbench
